// File: pcl_device.sv
// Device end of the fast passive parallel configuration loader
// Notes on behaviour
// - Request low in user mode restarts configuration
// - Status held low during power-on delay
// - Completion low from power-up through transfer
// - Configuration clock ignored once the two extra falling edges after completion are counted
// - Host uses lines 15..0 wide, 7..0 narrow
// - Completion released only after error-free full stream
// - Host gives two falling edges after completion
// - Init-done low once enabled until init ends
// - One new word per configuration clock cycle
// - Words sampled on configuration clock rising edge
// - Request low drives status and completion low
`timescale 1ns/100ps
module pcl_device #(
  parameter int POR_CYCLES = pcl_pkg::STATUS_LOW_CYCLES,
  parameter int INIT_CYCLES = pcl_pkg::INIT_CYCLES,
  parameter int WORDS = pcl_pkg::BITSTREAM_WORDS
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Link pins
  pcl_if.device link,
  // User side
  input wire logic mode_wide_i,
  output logic [pcl_pkg::DATA_WIDTH-1:0] word_o,
  output logic word_valid_o,
  output logic user_mode_o,
  output logic config_error_o,
  output logic init_enable_o
);
  typedef enum logic [2:0] {st_por, st_load, st_done, st_init, st_user, st_error, st_reset} dev_state_t;

  localparam int SYNC_W = pcl_pkg::DATA_WIDTH + 2;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  logic clk_prev;
  dev_state_t state;
  dev_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] words;
  logic [31:0] next_words;
  logic [pcl_pkg::DATA_WIDTH-1:0] csum;
  logic [pcl_pkg::DATA_WIDTH-1:0] next_csum;
  logic wide;
  logic next_wide;
  logic init_en;
  logic next_init_en;
  logic [pcl_pkg::DATA_WIDTH-1:0] next_word;
  logic next_word_valid;
  logic err;
  logic next_err;
  logic req_n_s;
  logic clk_s;
  logic [pcl_pkg::DATA_WIDTH-1:0] data_s;
  logic rise;
  logic fall;
  logic [pcl_pkg::DATA_WIDTH-1:0] word_in;

  // Two-stage synchronisers for all link inputs
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      // Request and clock start at their idle high level
      sync1 <= {2'b11, {(pcl_pkg::DATA_WIDTH){1'b0}}};
      sync2 <= {2'b11, {(pcl_pkg::DATA_WIDTH){1'b0}}};
      clk_prev <= 1'b1;
    end
    else
    begin
      sync1 <= {link.config_request_n, link.config_clock, link.data};
      sync2 <= sync1;
      clk_prev <= sync2[SYNC_W-2];
    end
  end

  assign req_n_s = sync2[SYNC_W-1];
  assign clk_s = sync2[SYNC_W-2];
  assign data_s = sync2[pcl_pkg::DATA_WIDTH-1:0];
  assign rise = clk_s & ~clk_prev;
  assign fall = ~clk_s & clk_prev;
  // Narrow mode keeps only lines 7..0
  assign word_in = wide ? data_s : {{(pcl_pkg::DATA_WIDTH-pcl_pkg::NARROW_WIDTH){1'b0}},
                                    data_s[pcl_pkg::NARROW_WIDTH-1:0]};

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_words = words;
    next_csum = csum;
    next_wide = wide;
    next_init_en = init_en;
    next_word = word_o;
    next_word_valid = 1'b0;
    next_err = err;
    unique case (state)
      st_por:
      begin
        // Power-on delay; wide mode strap caught here
        next_wide = mode_wide_i;
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(POR_CYCLES - 1))
        begin
          next_state = st_load;
          next_cnt = '0;
        end
      end
      st_load:
      begin
        if (rise)
        begin
          next_word = word_in;
          next_word_valid = 1'b1;
          next_words = words + 32'h1;
          next_csum = csum ^ word_in;
          if (words == 32'h0)
          begin
            next_init_en = word_in[pcl_pkg::INIT_ENABLE_BIT];
          end
          // Last word must equal the xor of all earlier words
          if (words == 32'(WORDS - 1))
          begin
            if (csum == word_in)
            begin
              next_state = st_done;
            end
            else
            begin
              next_state = st_error;
              next_err = 1'b1;
            end
          end
        end
      end
      st_done:
      begin
        if (fall)
        begin
          next_cnt = cnt + 32'h1;
          if (cnt == 32'(pcl_pkg::EXTRA_FALLING_EDGES - 1))
          begin
            next_state = st_init;
            next_cnt = '0;
          end
        end
      end
      st_init:
      begin
        // Clock activity no longer watched
        next_cnt = cnt + 32'h1;
        if (cnt >= 32'(INIT_CYCLES - 1))
        begin
          next_state = st_user;
          next_cnt = '0;
        end
      end
      st_user:
      begin
        next_state = st_user;
      end
      st_error:
      begin
        next_state = st_error;
      end
      st_reset:
      begin
        if (req_n_s)
        begin
          next_state = st_por;
          next_cnt = '0;
        end
      end
    endcase
    // Request low from any state begins a fresh cycle
    if (!req_n_s)
    begin
      next_state = st_reset;
      next_cnt = '0;
      next_words = '0;
      next_csum = '0;
      next_init_en = 1'b0;
      next_err = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= st_por;
      cnt <= '0;
      words <= '0;
      csum <= '0;
      wide <= 1'b0;
      init_en <= 1'b0;
      word_o <= '0;
      word_valid_o <= 1'b0;
      err <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      words <= next_words;
      csum <= next_csum;
      wide <= next_wide;
      init_en <= next_init_en;
      word_o <= next_word;
      word_valid_o <= next_word_valid;
      err <= next_err;
    end
  end

  // Open-drain drivers
  assign link.status_oe = (state == st_por) || (state == st_reset) || (state == st_error);
  assign link.complete_oe = (state == st_por) || (state == st_load) || (state == st_reset) ||
                            (state == st_error);
  // Init-done stays low in error once enabled, since initialization never completes
  assign link.init_done_oe = init_en && ((state == st_load) || (state == st_done) || (state == st_init) ||
                                         (state == st_error));
  assign user_mode_o = (state == st_user);
  assign config_error_o = err;
  assign init_enable_o = init_en;
endmodule

// File: pcl_pkg.sv
// Shared constants for the parallel configuration loader
package pcl_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DATA_WIDTH = 16;
  localparam int NARROW_WIDTH = 8;
  localparam int BITSTREAM_WORDS = 16;
  localparam int REQ_LOW_US = 2;
  localparam int REQ_LOW_CYCLES = (REQ_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_LOW_US = 268;
  localparam int STATUS_LOW_CYCLES = (STATUS_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ST2CK_US = 2;
  localparam int ST2CK_CYCLES = (ST2CK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INIT_US = 175;
  localparam int INIT_CYCLES = (INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXTRA_FALLING_EDGES = 2;
  localparam int CLOCK_HALF_CYCLES = 4;
  localparam int DONE_WAIT_CYCLES = 64;
  localparam int INIT_ENABLE_BIT = 0;
endpackage

// File: pcl_if.sv
// Pins between the configuration host and the loading device
`timescale 1ns/100ps
interface pcl_if;
  logic config_request_n;
  logic config_clock;
  logic [pcl_pkg::DATA_WIDTH-1:0] data;
  logic status_oe;
  logic complete_oe;
  logic init_done_oe;
  logic status_n;
  logic config_complete;
  logic init_done;
  // Open-drain pins with pull-ups
  assign status_n = ~status_oe;
  assign config_complete = ~complete_oe;
  assign init_done = ~init_done_oe;
  modport device (
    input config_request_n,
    input config_clock,
    input data,
    output status_oe,
    output complete_oe,
    output init_done_oe
  );
  modport host (
    output config_request_n,
    output config_clock,
    output data,
    input status_n,
    input config_complete,
    input init_done
  );
endinterface

// File: pcl_host.sv
// Host end of the fast passive parallel configuration loader
`timescale 1ns/100ps
module pcl_host #(
  parameter int WORDS = pcl_pkg::BITSTREAM_WORDS,
  parameter int HALF_CYCLES = pcl_pkg::CLOCK_HALF_CYCLES,
  parameter int DONE_WAIT = pcl_pkg::DONE_WAIT_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Link pins
  pcl_if.host link,
  // User side
  input wire logic start_i,
  input wire logic mode_wide_i,
  input wire logic [pcl_pkg::DATA_WIDTH-1:0] word_i,
  input wire logic word_valid_i,
  output logic word_ready_o,
  output logic busy_o,
  output logic done_o,
  output logic fail_o
);
  typedef enum logic [3:0] {h_idle, h_req, h_wait_status, h_gap, h_fetch, h_low, h_high, h_wait_done,
                            h_extra_low, h_extra_high, h_done, h_fail} host_state_t;

  logic [1:0] sync1;
  logic [1:0] sync2;
  host_state_t state;
  host_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [31:0] sent;
  logic [31:0] next_sent;
  logic req_n;
  logic next_req_n;
  logic cclk;
  logic next_cclk;
  logic [pcl_pkg::DATA_WIDTH-1:0] data;
  logic [pcl_pkg::DATA_WIDTH-1:0] next_data;
  logic status_s;
  logic complete_s;
  logic half_done;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= {link.status_n, link.config_complete};
      sync2 <= sync1;
    end
  end

  assign status_s = sync2[1];
  assign complete_s = sync2[0];
  assign half_done = (cnt >= 32'(HALF_CYCLES - 1));

  always_comb
  begin
    next_state = state;
    next_cnt = cnt + 32'h1;
    next_sent = sent;
    next_req_n = req_n;
    next_cclk = cclk;
    next_data = data;
    unique case (state)
      h_idle, h_done, h_fail:
      begin
        next_cnt = '0;
        if (start_i)
        begin
          next_state = h_req;
          next_req_n = 1'b0;
          next_sent = '0;
        end
      end
      h_req:
      begin
        if (cnt >= 32'(pcl_pkg::REQ_LOW_CYCLES - 1))
        begin
          next_state = h_wait_status;
          next_req_n = 1'b1;
          next_cnt = '0;
        end
      end
      h_wait_status:
      begin
        next_cnt = '0;
        if (status_s)
        begin
          next_state = h_gap;
        end
      end
      h_gap:
      begin
        if (cnt >= 32'(pcl_pkg::ST2CK_CYCLES - 1))
        begin
          next_state = h_fetch;
        end
      end
      h_fetch:
      begin
        next_cnt = '0;
        if (word_valid_i)
        begin
          // One word per clock period, set up at the falling edge
          next_data = mode_wide_i ? word_i : {{(pcl_pkg::DATA_WIDTH-pcl_pkg::NARROW_WIDTH){1'b0}},
                                              word_i[pcl_pkg::NARROW_WIDTH-1:0]};
          next_cclk = 1'b0;
          next_state = h_low;
        end
      end
      h_low, h_extra_low:
      begin
        if (half_done)
        begin
          next_cclk = 1'b1;
          next_cnt = '0;
          next_state = (state == h_low) ? h_high : h_extra_high;
        end
      end
      h_high:
      begin
        if (half_done)
        begin
          next_sent = sent + 32'h1;
          next_cnt = '0;
          next_state = (sent == 32'(WORDS - 1)) ? h_wait_done : h_fetch;
        end
      end
      h_wait_done:
      begin
        if (complete_s)
        begin
          next_state = h_extra_low;
          next_cclk = 1'b0;
          next_cnt = '0;
          next_sent = '0;
        end
        else if (cnt >= 32'(DONE_WAIT - 1))
        begin
          next_state = h_fail;
        end
      end
      h_extra_high:
      begin
        if (half_done)
        begin
          next_sent = sent + 32'h1;
          next_cnt = '0;
          next_cclk = 1'b0;
          next_state = h_extra_low;
          if (sent == 32'(pcl_pkg::EXTRA_FALLING_EDGES - 1))
          begin
            next_cclk = 1'b1;
            next_state = h_done;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state <= h_idle;
      cnt <= '0;
      sent <= '0;
      req_n <= 1'b1;
      cclk <= 1'b1;
      data <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      sent <= next_sent;
      req_n <= next_req_n;
      cclk <= next_cclk;
      data <= next_data;
    end
  end

  assign link.config_request_n = req_n;
  assign link.config_clock = cclk;
  assign link.data = data;
  assign word_ready_o = (state == h_fetch);
  assign busy_o = (state != h_idle) && (state != h_done) && (state != h_fail);
  assign done_o = (state == h_done);
  assign fail_o = (state == h_fail);
endmodule

// File: pcl_link_monitor.sv
// Link checker for the parallel configuration loader
`timescale 1ns/100ps
module pcl_link_monitor (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // Link pins
  input wire logic config_request_n,
  input wire logic config_clock,
  input wire logic [pcl_pkg::DATA_WIDTH-1:0] data,
  input wire logic status_oe,
  input wire logic complete_oe,
  input wire logic init_done_oe
);
  localparam int WORDS = pcl_pkg::BITSTREAM_WORDS;
  logic clock_prev;
  int rises;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  // Rising clock edges seen since the last request
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      clock_prev <= 1'b1;
      rises <= 0;
    end
    else
    begin
      clock_prev <= config_clock;
      if (!config_request_n)
      begin
        rises <= 0;
      end
      else if (config_clock && !clock_prev && (rises < WORDS))
      begin
        rises <= rises + 1;
      end
    end
  end
  sequence s_release;
    $fell(complete_oe);
  endsequence
  sequence s_two_falls;
    ##[1:40] $fell(config_clock) ##[1:20] $fell(config_clock);
  endsequence
  chk_req_pulls_low: assert property (
    $fell(config_request_n) |-> ##[1:8] (status_oe && complete_oe)) else $error("request low not answered");
  chk_por_status: assert property (
    $rose(nrst_i) |-> status_oe [*8]) else $error("status released during power-on");
  chk_low_in_transfer: assert property (
    config_request_n && (rises < WORDS) |-> complete_oe) else $error("complete released before last word");
  chk_release_clean: assert property (
    s_release |-> config_request_n && !status_oe) else $error("complete released without clean stream");
  chk_two_falls: assert property (
    s_release |-> s_two_falls) else $error("extra falling edges missing");
  chk_clock_ignored: assert property (
    !complete_oe && config_request_n |=> !complete_oe) else $error("complete dropped after finish");
  chk_init_end: assert property (
    $fell(init_done_oe) && config_request_n |-> !complete_oe && !status_oe) else $error("init done released too early");
  chk_clock_phase: assert property (
    $rose(config_clock) |-> config_clock [*4]) else $error("clock high phase too short");
  chk_data_stable: assert property (
    config_clock && $past(config_clock) |-> $stable(data)) else $error("data moved while clock high");
  chk_clock_gated: assert property (
    $fell(config_clock) |-> config_request_n && !status_oe) else $error("clock edge while status low");
endmodule

// File: parallel_config_loader_tb_top.sv
// Testbench joining host and device ends of the loader
`timescale 1ns/100ps
module parallel_config_loader_tb_top;
  localparam int WORDS = pcl_pkg::BITSTREAM_WORDS;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic start = 1'b0;
  logic mode_wide = 1'b1;
  logic [pcl_pkg::DATA_WIDTH-1:0] word = 16'h0000;
  logic word_valid = 1'b0;
  logic word_ready, busy, done, fail, user_mode, cfg_err, init_en, dev_valid;
  logic [pcl_pkg::DATA_WIDTH-1:0] dev_word;
  logic [31:0] seed = 32'hea8a3cec;
  int failures = 0;
  int n_compared = 0;
  logic [pcl_pkg::DATA_WIDTH-1:0] exp_q[$];
  pcl_if link_a();
  pcl_device #(.POR_CYCLES(20), .INIT_CYCLES(20), .WORDS(WORDS)) u_pcl_device (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .link(link_a), .mode_wide_i(mode_wide), .word_o(dev_word), .word_valid_o(dev_valid), .user_mode_o(user_mode),
    .config_error_o(cfg_err), .init_enable_o(init_en));
  pcl_host #(.WORDS(WORDS)) u_pcl_host (.mclk_i(mclk_i), .nrst_i(nrst_i), .link(link_a), .start_i(start),
    .mode_wide_i(mode_wide), .word_i(word), .word_valid_i(word_valid), .word_ready_o(word_ready), .busy_o(busy),
    .done_o(done), .fail_o(fail));
  pcl_link_monitor u_pcl_link_monitor (.mclk_i(mclk_i), .nrst_i(nrst_i), .config_request_n(link_a.config_request_n),
    .config_clock(link_a.config_clock), .data(link_a.data), .status_oe(link_a.status_oe),
    .complete_oe(link_a.complete_oe), .init_done_oe(link_a.init_done_oe));
  initial
  begin
    forever #2 mclk_i = ~mclk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk_bit(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Each received word against the queue of sent words
  always @(posedge mclk_i)
    if (dev_valid === 1'b1)
      chk_word("received word", exp_q.pop_front(), dev_word);
  task automatic do_reset(input logic wide);
    nrst_i <= 1'b0;
    mode_wide <= wide;
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    chk_bit("status after reset", 1'b0, link_a.status_n);
    chk_bit("complete after reset", 1'b0, link_a.config_complete);
  endtask
  task automatic run_cfg(input logic bad);
    logic [15:0] w;
    logic [15:0] sum;
    sum = 16'h0000;
    start <= 1'b1;
    @(posedge mclk_i);
    start <= 1'b0;
    repeat (10) @(posedge mclk_i);
    chk_bit("status on request", 1'b0, link_a.status_n);
    chk_bit("complete on request", 1'b0, link_a.config_complete);
    chk_bit("user mode on request", 1'b0, user_mode);
    chk_bit("host busy", 1'b1, busy);
    for (int i = 0; i < WORDS; i++)
    begin
      seed = lfsr(seed);
      w = (i == 0) ? (seed[15:0] | 16'h0001) : seed[15:0];
      if (i == WORDS - 1)
        w = sum ^ {15'h0000, bad};
      sum = sum ^ w;
      exp_q.push_back(mode_wide ? w : {8'h00, w[7:0]});
      word <= w;
      word_valid <= 1'b1;
      do @(posedge mclk_i); while (word_ready !== 1'b1);
    end
    word_valid <= 1'b0;
    for (int k = 0; k < 4000 && done !== 1'b1 && fail !== 1'b1; k++)
      @(posedge mclk_i);
    chk_bit("host done", !bad, done);
    chk_bit("host fail", bad, fail);
    chk_bit("complete", !bad, link_a.config_complete);
    chk_bit("status", !bad, link_a.status_n);
    chk_bit("error flag", bad, cfg_err);
    chk_bit("host idle", 1'b0, busy);
    chk_word("words left", 16'h0000, 16'(exp_q.size()));
    if (!bad)
    begin
      chk_bit("init done early", 1'b0, link_a.init_done);
      repeat (40) @(posedge mclk_i);
      chk_bit("user mode", 1'b1, user_mode);
      chk_bit("init done", 1'b1, link_a.init_done);
      chk_bit("init enable", 1'b1, init_en);
    end
    else
    begin
      chk_bit("init done held", 1'b0, link_a.init_done);
      chk_bit("user mode held", 1'b0, user_mode);
    end
  endtask
  initial
  begin
    do_reset(1'b1);
    run_cfg(1'b0);
    run_cfg(1'b1);
    run_cfg(1'b0);
    run_cfg(1'b0);
    do_reset(1'b0);
    run_cfg(1'b0);
    final_report;
  end
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    final_report;
  end
endmodule
